// File: bench/srwf_formatter_test.sv
// Self-checking bench of the satellite reply word formatter.
// Assumes the host model owns the link pins; events are pulses on the system clock.
`timescale 1ns/100ps
`include "srwf_consts.svh"
module srwf_formatter_test
  import srwf_pkg::*;
;
  localparam logic [11:0] EXP_A [6] = '{`SRWF_CODE_A_BIT_TIME, `SRWF_CODE_A_FEW,
    `SRWF_CODE_A_FEW, `SRWF_CODE_A_CRC, `SRWF_CODE_CUR_LIM, `SRWF_CODE_CMD_PAR};
  localparam logic [11:0] EXP_B [6] = '{`SRWF_CODE_B_FEW, `SRWF_CODE_B_FEW,
    `SRWF_CODE_B_MANY, `SRWF_CODE_B_PAR, `SRWF_CODE_CUR_LIM, `SRWF_CODE_CMD_PAR};
  localparam logic [1:0] ST_OF_EN [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic sys_clk_i;
  logic reset_n_i;
  wire spi_sclk;
  wire spi_cs_n;
  wire miso_line;
  logic spi_miso;
  logic spi_miso_oe;
  logic miso_hold = 1'b0;
  logic [1:0][1:0] cfg_en;
  logic [1:0] proto_b;
  logic [1:0][1:0] b_width;
  logic [12:0] main_channel_config;
  logic [1:0][12:0] per_channel_config;
  logic rep_load;
  logic rep_chan;
  srwf_rep_t rep_sel;
  logic xfer_chan;
  logic [1:0] sens_v;
  logic [1:0][11:0] sens_d;
  logic [1:0][5:0] fault;
  logic bad_cnt;
  logic [1:0] flush;
  logic [15:0] reply_word;
  logic [1:0] fifo_empty;
  logic [1:0] data_lost;
  logic [15:0] rx_word;
  logic rx_is_data;
  int bad_count;
  int n_tests;
  int cyc = 0;

  // A released data line shows the inverse of its last driven level.
  assign miso_line = spi_miso_oe ? spi_miso : ~miso_hold;
  always @(negedge spi_miso_oe) miso_hold = spi_miso;

  srwf_formatter u_srwf_formatter (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(spi_sclk),
    .spi_cs_n_i(spi_cs_n), .spi_miso_o(spi_miso), .spi_miso_oe_o(spi_miso_oe),
    .per_channel_config_en_i(cfg_en), .proto_b_i(proto_b), .b_field_width_i(b_width),
    .main_channel_config_i(main_channel_config), .per_channel_config_i(per_channel_config), .rep_load_i(rep_load),
    .rep_chan_i(rep_chan), .rep_sel_i(rep_sel), .xfer_chan_i(xfer_chan),
    .sensor_valid_i(sens_v), .sensor_data_i(sens_d), .chan_fault_i(fault),
    .bad_bit_count_i(bad_cnt), .flush_i(flush), .reply_word_o(reply_word),
    .fifo_empty_o(fifo_empty), .data_lost_o(data_lost));

  srwf_host_model u_srwf_host_model (
    .spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n), .spi_miso_i(miso_line),
    .rx_word_o(rx_word), .rx_is_data_o(rx_is_data));

  function automatic logic [15:0] fw(input logic [1:0] st, input logic dl,
                                     input logic [11:0] pay);
    fw = {st, ~^{st, dl, pay}, dl, pay};
  endfunction

  task automatic complete_run();
    $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk_i);
    #5;
  endtask

  task automatic chk_w(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic chk_b(input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t exp %h got %h", $time, exp, got);
    end
  endtask

  // Channel two frames use a slower lead-in before the first serial clock.
  task automatic frame(input logic ch, input logic [15:0] exp);
    tick();
    xfer_chan = ch;
    repeat (4) tick();
    u_srwf_host_model.xfer(proto_b[ch], 240 + 200 * ch);
    chk_w(exp, rx_word);
  endtask

  task automatic push(input logic ch, input logic [11:0] d);
    tick();
    sens_v[ch] = 1'b1;
    sens_d[ch] = d;
    tick();
    sens_v[ch] = 1'b0;
  endtask

  task automatic pulse_fault(input logic ch, input int b);
    tick();
    fault[ch][b] = 1'b1;
    tick();
    fault[ch] = 6'h00;
  endtask

  task automatic load(input logic ch, input srwf_rep_t sel);
    tick();
    rep_load = 1'b1;
    rep_chan = ch;
    rep_sel = sel;
    tick();
    rep_load = 1'b0;
  endtask

  task automatic t_reset_reply();
    frame(1'b0, {2'h3, ~^main_channel_config, main_channel_config});
    frame(1'b1, `SRWF_FIXED_REPLY);
    load(1'b1, SRWF_REP_CCR);
    frame(1'b1, {2'h3, ~^per_channel_config[1], per_channel_config[1]});
    load(1'b1, SRWF_REP_MCR);
    frame(1'b1, `SRWF_FIXED_REPLY);
    load(1'b0, SRWF_REP_FIFO);
    load(1'b1, SRWF_REP_FIFO);
  endtask

  task automatic t_status();
    for (int e = 0; e < 4; e++) begin
      tick();
      cfg_en[0] = e[1:0];
      frame(1'b0, fw(ST_OF_EN[e], 1'b0, `SRWF_CODE_NONE));
    end
    tick();
    cfg_en = {2'h2, 2'h2};
    fork
      frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
      begin
        repeat (12) tick();
        cfg_en[0] = 2'h0;
      end
    join
    frame(1'b0, fw(2'h0, 1'b0, `SRWF_CODE_NONE));
    tick();
    cfg_en[0] = 2'h2;
  endtask

  task automatic t_queue();
    push(1'b0, 12'h123);
    push(1'b0, 12'h456);
    chk_b(1'b0, fifo_empty[0]);
    tick();
    chk_w(fw(2'h2, 1'b0, 12'h123), reply_word);
    frame(1'b0, fw(2'h2, 1'b0, 12'h123));
    frame(1'b0, fw(2'h2, 1'b0, 12'h456));
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
    chk_b(1'b1, fifo_empty[0]);
  endtask

  task automatic t_lost_flush();
    push(1'b1, 12'h321);
    push(1'b1, 12'h654);
    push(1'b1, 12'h777);
    chk_b(1'b1, data_lost[1]);
    frame(1'b1, fw(2'h2, 1'b1, 12'h321));
    frame(1'b1, fw(2'h2, 1'b0, 12'h654));
    push(1'b0, 12'h0AA);
    push(1'b0, 12'h0BB);
    tick();
    flush[0] = 1'b1;
    tick();
    flush[0] = 1'b0;
    chk_b(1'b1, fifo_empty[0]);
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
  endtask

  task automatic t_faults();
    for (int p = 0; p < 2; p++) begin
      tick();
      proto_b[0] = p[0];
      for (int b = 0; b < 6; b++) begin
        pulse_fault(1'b0, b);
        frame(1'b0, fw(2'h2, 1'b0, p ? EXP_B[b] : EXP_A[b]));
        chk_b(1'b0, rx_is_data);
      end
    end
  endtask

  task automatic t_data();
    tick();
    proto_b[0] = 1'b0;
    push(1'b0, 12'h015);
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_RESERVED));
    push(1'b0, 12'h020);
    frame(1'b0, fw(2'h2, 1'b0, 12'h020));
    chk_b(1'b1, rx_is_data);
    tick();
    proto_b[0] = 1'b1;
    b_width[0] = 2'h0;
    push(1'b0, 12'h1A5);
    frame(1'b0, fw(2'h2, 1'b0, 12'h8A5));
    tick();
    b_width[0] = 2'h3;
    push(1'b0, 12'h7FF);
    frame(1'b0, fw(2'h2, 1'b0, 12'hFFF));
    chk_b(1'b1, rx_is_data);
    tick();
    proto_b[0] = 1'b0;
  endtask

  task automatic t_global();
    tick();
    bad_cnt = 1'b1;
    repeat (5) tick();
    bad_cnt = 1'b0;
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_BAD_CNT));
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
    frame(1'b1, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
    pulse_fault(1'b1, 4);
    pulse_fault(1'b1, 4);
    frame(1'b1, fw(2'h2, 1'b0, `SRWF_CODE_CUR_LIM));
    frame(1'b1, fw(2'h2, 1'b0, `SRWF_CODE_CUR_LIM));
    frame(1'b0, fw(2'h2, 1'b0, `SRWF_CODE_NONE));
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    bad_count = 0;
    n_tests = 0;
    reset_n_i = 1'b0;
    cfg_en = '0;
    proto_b = 2'h0;
    b_width = '0;
    main_channel_config = 13'h0A5C;
    per_channel_config = {13'h1234, 13'h0F0F};
    rep_load = 1'b0;
    rep_chan = 1'b0;
    rep_sel = SRWF_REP_FIFO;
    xfer_chan = 1'b0;
    sens_v = 2'h0;
    sens_d = '0;
    fault = '0;
    bad_cnt = 1'b0;
    flush = 2'h0;
    repeat (20) @(posedge sys_clk_i);
    #5;
    reset_n_i = 1'b1;
    repeat (4) tick();
    t_reset_reply();
    t_status();
    t_queue();
    t_lost_flush();
    t_faults();
    t_data();
    t_global();
    complete_run();
  end
endmodule

// File: bench/srwf_host_model.sv
// Host side of the satellite link: a master that frames one reply word at a time.
// Assumes the bench calls xfer while chip select is high and the formatter is out of reset.
`timescale 1ns/100ps
module srwf_host_model (
  // Link pins
  output logic spi_sclk_o,
  output logic spi_cs_n_o,
  input wire logic spi_miso_i,
  // Last reply and how it was read
  output logic [15:0] rx_word_o,
  output logic rx_is_data_o
);
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    rx_word_o = 16'h0000;
    rx_is_data_o = 1'b0;
  end

  // The serial clock stands low outside frames and toggles every 24 ns inside them.
  task automatic xfer(input logic proto_b, input int lead);
    logic [15:0] w;
    w = 16'h0000;
    spi_cs_n_o = 1'b0;
    #(lead);
    for (int i = 15; i >= 0; i--) begin
      spi_sclk_o = 1'b1;
      w[i] = spi_miso_i;
      #24;
      spi_sclk_o = 1'b0;
      #24;
    end
    spi_cs_n_o = 1'b1;
    rx_word_o = w;
    if (w[15:14] == 2'h3) begin
      rx_is_data_o = 1'b0;
    end else if (proto_b) begin
      rx_is_data_o = w[11];
    end else begin
      rx_is_data_o = (w[11:0] >= 12'h020);
    end
    #300;
  endtask
endmodule

// File: rtl/srwf_chan_fifo.sv
// Per-channel reply queue with a sticky lost-word flag.
// Assumes push, pop and flush are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module srwf_chan_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 2,
  parameter int LW = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Filling side
  input wire logic push_i,
  input wire logic [W-1:0] push_data_i,
  // Draining side
  input wire logic pop_i,
  input wire logic flush_i,
  // Queue state
  output logic [W-1:0] head_o,
  output logic empty_o,
  output logic full_o,
  output logic [LW-1:0] level_o,
  output logic lost_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [LW-1:0] lvl;
    logic lost;
  } srwf_fifo_t;

  srwf_fifo_t r;
  srwf_fifo_t n;
  logic do_pop;
  logic do_push;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  assign do_pop = pop_i && (r.lvl != '0);
  assign do_push = push_i && ((r.lvl != LW'(DEPTH)) || do_pop);

  always_comb begin
    n = r;
    if (flush_i) begin
      n.rd = '0;
      n.wr = '0;
      n.lvl = '0;
    end else begin
      if (do_push) begin
        n.mem[r.wr] = push_data_i;
        n.wr = bump(r.wr);
      end
      if (do_pop) begin
        n.rd = bump(r.rd);
      end
      if (do_push && !do_pop) begin
        n.lvl = r.lvl + LW'(1);
      end else if (do_pop && !do_push) begin
        n.lvl = r.lvl - LW'(1);
      end
    end
    if (pop_i) begin
      n.lost = 1'b0;
    end
    if (push_i && !do_push) begin
      n.lost = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign head_o = r.mem[r.rd];
  assign empty_o = (r.lvl == '0);
  assign full_o = (r.lvl == LW'(DEPTH));
  assign level_o = r.lvl;
  assign lost_o = r.lost;
endmodule

// File: rtl/srwf_consts.svh
// Constants of the satellite reply word formatter: field positions, payload codes, sizes.
// Included by bare name from the formatter of the rtl folder and from the bench.
// Behaviour
// - Capture the two status bits of the reply when chip select falls.
// - On chip select rising, drop the reported entry from that channel's queue.
// - Every fault is a payload code between 001 and 01F hex.
// - Global faults concern all channels; channel faults only their own channel. The code queues the global fault on the first channel only.
// - Channel faults queue per occurrence; a global fault queues once while present.
// - Bit 13 makes the count of ones in each reply word odd.
// - In a queue reply, bit 12 reads one when a word arrived at a full queue, else zero.
// - The low twelve bits carry the queue head, fault code or sensor data.
// - Status 00 off, 01 on idle, 10 on processing, 11 configuration report.
// - An empty queue reports payload zero.
// - Bad command bit count is code 2, first channel only, queued once.
// - High-side current limit exceeded queues code 10 hex.
// - Command odd parity failure queues code 12 hex.
// - First protocol data from 0 to 1F hex becomes code 18 hex.
// - First protocol: bit time 19, time or too few 1A, CRC 1C.
// - Second protocol: time or too few 19, too many 1A, parity 1C.
// - After reset channel one reports main config, channel two E000 hex.
// - Second protocol data is right justified with payload bit 11 set.
// - Each queue holds two entries; a flush empties the addressed one.
`ifndef SRWF_CONSTS_SVH
`define SRWF_CONSTS_SVH
`define SRWF_WORD_W 16
`define SRWF_PAYLOAD_W 12
`define SRWF_PAR_BIT 13
`define SRWF_DL_BIT 12
`define SRWF_B_MARK_BIT 11
`define SRWF_CFG_W 13
`define SRWF_CODE_NONE 12'h000
`define SRWF_CODE_MIN 12'h001
`define SRWF_CODE_MAX 12'h01F
`define SRWF_CODE_BAD_CNT 12'h002
`define SRWF_CODE_CUR_LIM 12'h010
`define SRWF_CODE_CMD_PAR 12'h012
`define SRWF_CODE_RESERVED 12'h018
`define SRWF_CODE_A_BIT_TIME 12'h019
`define SRWF_CODE_A_FEW 12'h01A
`define SRWF_CODE_A_CRC 12'h01C
`define SRWF_CODE_B_FEW 12'h019
`define SRWF_CODE_B_MANY 12'h01A
`define SRWF_CODE_B_PAR 12'h01C
`define SRWF_FIXED_REPLY 16'hE000
`define SRWF_B_FULL_MASK 11'h7FF
`define SRWF_B_WIDTH_MAX 2'h3
`define SRWF_FK_BIT_TIME 0
`define SRWF_FK_FEW 1
`define SRWF_FK_MANY 2
`define SRWF_FK_CHECK 3
`define SRWF_FK_CUR_LIM 4
`define SRWF_FK_CMD_PAR 5
`define SRWF_FK_W 6
`define SRWF_FIFO_DEPTH 2
`define SRWF_CHANNELS 2
`endif

// File: rtl/srwf_formatter.sv
// Satellite reply word formatter: queues sensor data and fault codes per channel
// and shifts the 16-bit reply out on the satellite serial link.
// Assumes event inputs come from logic on sys_clk_i; the link pins are asynchronous.
// The host leaves at least four system clocks between chip select falling and the
// first serial clock edge, so the frozen reply word is stable when it is shifted.
`timescale 1ns/100ps
`include "srwf_consts.svh"
module srwf_formatter
  import srwf_pkg::*;
#(
  parameter int N_CH = `SRWF_CHANNELS,
  parameter int FIFO_DEPTH = `SRWF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Satellite serial link
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // Channel configuration
  input wire logic [N_CH-1:0][1:0] per_channel_config_en_i,
  input wire logic [N_CH-1:0] proto_b_i,
  input wire logic [N_CH-1:0][1:0] b_field_width_i,
  input wire logic [`SRWF_CFG_W-1:0] main_channel_config_i,
  input wire logic [N_CH-1:0][`SRWF_CFG_W-1:0] per_channel_config_i,
  // Reply selection
  input wire logic rep_load_i,
  input wire logic [$clog2(N_CH)-1:0] rep_chan_i,
  input wire srwf_rep_t rep_sel_i,
  input wire logic [$clog2(N_CH)-1:0] xfer_chan_i,
  // Decoder and fault events
  input wire logic [N_CH-1:0] sensor_valid_i,
  input wire logic [N_CH-1:0][`SRWF_PAYLOAD_W-1:0] sensor_data_i,
  input wire logic [N_CH-1:0][`SRWF_FK_W-1:0] chan_fault_i,
  input wire logic bad_bit_count_i,
  input wire logic [N_CH-1:0] flush_i,
  // Status
  output logic [`SRWF_WORD_W-1:0] reply_word_o,
  output wire logic [N_CH-1:0] fifo_empty_o,
  output wire logic [N_CH-1:0] data_lost_o
);
  localparam int CW = $clog2(N_CH);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int PW = `SRWF_PAYLOAD_W;
  localparam int WW = `SRWF_WORD_W;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic glob_prev;
    logic [CW-1:0] chan;
    logic [WW-1:0] word;
    srwf_rep_t [N_CH-1:0] rep;
  } srwf_sys_t;

  typedef struct packed {
    logic [3:0] cnt;
  } srwf_link_t;

  function automatic srwf_rep_t [N_CH-1:0] init_rep();
    srwf_rep_t [N_CH-1:0] v;
    for (int i = 0; i < N_CH; i++) begin
      v[i] = SRWF_REP_FIXED;
    end
    v[0] = SRWF_REP_MCR;
    return v;
  endfunction

  localparam srwf_rep_t [N_CH-1:0] REP_RST = init_rep();
  localparam srwf_sys_t SYS_RST = '{
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    cs_prev: 1'b1,
    glob_prev: 1'b0,
    chan: '0,
    word: '0,
    rep: REP_RST
  };

  function automatic srwf_stat_t stat_of(input logic [1:0] en);
    srwf_stat_t s;
    unique case (en)
      2'h1: s = SRWF_ST_ON_IDLE;
      2'h2: s = SRWF_ST_ON_MSG;
      2'h0, 2'h3: s = SRWF_ST_OFF;
    endcase
    return s;
  endfunction

  function automatic logic [PW-1:0] fault_code(input logic b,
                                               input logic [`SRWF_FK_W-1:0] fk);
    if (fk[`SRWF_FK_CUR_LIM]) begin
      return `SRWF_CODE_CUR_LIM;
    end
    if (fk[`SRWF_FK_CMD_PAR]) begin
      return `SRWF_CODE_CMD_PAR;
    end
    if (fk[`SRWF_FK_CHECK]) begin
      return b ? `SRWF_CODE_B_PAR : `SRWF_CODE_A_CRC;
    end
    if (fk[`SRWF_FK_MANY]) begin
      return b ? `SRWF_CODE_B_MANY : `SRWF_CODE_A_FEW;
    end
    if (fk[`SRWF_FK_FEW]) begin
      return b ? `SRWF_CODE_B_FEW : `SRWF_CODE_A_FEW;
    end
    if (fk[`SRWF_FK_BIT_TIME]) begin
      return b ? `SRWF_CODE_B_FEW : `SRWF_CODE_A_BIT_TIME;
    end
    return `SRWF_CODE_NONE;
  endfunction

  function automatic logic [PW-1:0] data_code(input logic b, input logic [1:0] width,
                                              input logic [PW-1:0] data);
    logic [PW-2:0] m;
    logic [PW-1:0] c;
    m = `SRWF_B_FULL_MASK >> (`SRWF_B_WIDTH_MAX - width);
    c = data;
    if (b) begin
      c = {1'b0, data[PW-2:0] & m};
      c[`SRWF_B_MARK_BIT] = 1'b1;
    end else if (data <= `SRWF_CODE_MAX) begin
      c = `SRWF_CODE_RESERVED;
    end
    return c;
  endfunction

  function automatic logic [WW-1:0] build_word(input srwf_rep_t rep, input srwf_stat_t st,
                                               input logic dl, input logic empty,
                                               input logic [PW-1:0] head,
                                               input logic [`SRWF_CFG_W-1:0] main_channel_config,
                                               input logic [`SRWF_CFG_W-1:0] per_channel_config);
    logic [WW-1:0] w;
    unique case (rep)
      SRWF_REP_MCR: w = {SRWF_ST_CFG, 1'b0, main_channel_config};
      SRWF_REP_CCR: w = {SRWF_ST_CFG, 1'b0, per_channel_config};
      SRWF_REP_FIXED: w = `SRWF_FIXED_REPLY;
      SRWF_REP_FIFO: w = {st, 1'b0, dl, empty ? `SRWF_CODE_NONE : head};
    endcase
    w[`SRWF_PAR_BIT] = 1'b0;
    w[`SRWF_PAR_BIT] = ~^w;
    return w;
  endfunction

  srwf_sys_t r;
  srwf_sys_t n;
  srwf_link_t lr;
  srwf_link_t ln;
  logic cs_rise;
  logic fifo_rep;
  srwf_stat_t cur_stat;
  logic [PW-1:0] head [N_CH];
  logic empty [N_CH];
  logic full [N_CH];
  logic lost [N_CH];
  logic [LW-1:0] lvl [N_CH];
  logic [WW-1:0] words [N_CH];
  logic push [N_CH];
  logic pop [N_CH];
  logic glob [N_CH];
  logic [PW-1:0] code [N_CH];

  assign cs_rise = r.cs_sync && !r.cs_prev;
  assign fifo_rep = (r.word[WW-1 -: 2] != SRWF_ST_CFG);
  assign cur_stat = stat_of(per_channel_config_en_i[xfer_chan_i]);

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    assign glob[c] = (c == 0) && bad_bit_count_i && !r.glob_prev;
    assign code[c] = glob[c] ? `SRWF_CODE_BAD_CNT :
                     (|chan_fault_i[c]) ? fault_code(proto_b_i[c], chan_fault_i[c]) :
                     data_code(proto_b_i[c], b_field_width_i[c], sensor_data_i[c]);
    assign push[c] = glob[c] || (|chan_fault_i[c]) || sensor_valid_i[c];
    assign pop[c] = cs_rise && (r.chan == CW'(c)) && fifo_rep;
    assign words[c] = build_word(r.rep[c], stat_of(per_channel_config_en_i[c]), lost[c],
                                 empty[c], head[c], main_channel_config_i,
                                 per_channel_config_i[c]);

    srwf_chan_fifo #(
      .W(PW),
      .DEPTH(FIFO_DEPTH),
      .LW(LW)
    ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .push_i(push[c]),
      .push_data_i(code[c]),
      .pop_i(pop[c]),
      .flush_i(flush_i[c]),
      .head_o(head[c]),
      .empty_o(empty[c]),
      .full_o(full[c]),
      .level_o(lvl[c]),
      .lost_o(lost[c])
    );

    assign fifo_empty_o[c] = empty[c];
    assign data_lost_o[c] = lost[c];

    AST_POP_DROPS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      pop[c] && !push[c] && !flush_i[c] && (lvl[c] != '0)
      |=> lvl[c] == $past(lvl[c]) - LW'(1))
      else $error("Reported entry was not removed");

    AST_FAULT_RANGE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && (glob[c] || (|chan_fault_i[c]))
      |-> (code[c] >= `SRWF_CODE_MIN) && (code[c] <= `SRWF_CODE_MAX))
      else $error("Fault code outside its range");

    AST_DATA_LOST: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && full[c] && !pop[c] && !flush_i[c] |=> lost[c])
      else $error("Word lost at a full queue without flag");

    AST_EMPTY_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      r.cs_sync && (xfer_chan_i == CW'(c)) && (r.rep[c] == SRWF_REP_FIFO) && empty[c]
      |=> r.word[PW-1:0] == `SRWF_CODE_NONE)
      else $error("Empty queue gave a nonzero payload");

    AST_RESERVED_DATA: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && !glob[c] && !(|chan_fault_i[c]) && !proto_b_i[c]
      && (sensor_data_i[c] <= `SRWF_CODE_MAX) |-> code[c] == `SRWF_CODE_RESERVED)
      else $error("Low sensor value not turned into a fault");

    AST_B_MARK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && !glob[c] && proto_b_i[c]
      |-> code[c][`SRWF_B_MARK_BIT] == !(|chan_fault_i[c]))
      else $error("Payload bit 11 does not tell data from fault");

    AST_CUR_LIM: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && !glob[c] && chan_fault_i[c][`SRWF_FK_CUR_LIM]
      |-> code[c] == `SRWF_CODE_CUR_LIM)
      else $error("Current limit fault gave the wrong code");

    AST_CMD_PAR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      push[c] && !glob[c] && chan_fault_i[c][`SRWF_FK_CMD_PAR]
      && !chan_fault_i[c][`SRWF_FK_CUR_LIM] |-> code[c] == `SRWF_CODE_CMD_PAR)
      else $error("Command parity fault gave the wrong code");

    AST_FLUSH_EMPTY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      flush_i[c]
      |=> empty[c])
      else $error("Flushed queue is not empty");
  end

  always_comb begin
    n = r;
    n.cs_meta = spi_cs_n_i;
    n.cs_sync = r.cs_meta;
    n.cs_prev = r.cs_sync;
    n.glob_prev = bad_bit_count_i;
    if (r.cs_sync) begin
      n.chan = xfer_chan_i;
      n.word = words[xfer_chan_i];
    end
    if (rep_load_i) begin
      n.rep[rep_chan_i] = rep_sel_i;
      if ((rep_sel_i == SRWF_REP_MCR) && (rep_chan_i != '0)) begin
        n.rep[rep_chan_i] = SRWF_REP_FIXED;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= SYS_RST;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    ln = lr;
    ln.cnt = lr.cnt + 4'h1;
  end

  always_ff @(negedge spi_sclk_i or negedge reset_n_i or posedge spi_cs_n_i) begin
    if (!reset_n_i) begin
      lr <= '0;
    end else if (spi_cs_n_i) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  assign spi_miso_o = r.word[~lr.cnt];
  assign spi_miso_oe_o = !spi_cs_n_i;
  assign reply_word_o = r.word;

  sequence s_cs_fall;
    r.cs_prev && !r.cs_sync;
  endsequence

  sequence s_selected;
    !r.cs_prev && !r.cs_sync;
  endsequence

  AST_STATUS_LATCH: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    r.cs_sync && (r.rep[xfer_chan_i] == SRWF_REP_FIFO)
    |=> r.word[WW-1 -: 2] == $past(cur_stat))
    else $error("Status bits not captured from channel state");

  AST_CFG_STATUS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    r.cs_sync && (r.rep[xfer_chan_i] != SRWF_REP_FIFO)
    |=> r.word[WW-1 -: 2] == SRWF_ST_CFG)
    else $error("Configuration reply without report status");

  AST_WORD_HELD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_cs_fall ##1 s_selected |-> $stable(r.word))
    else $error("Reply word changed during a frame");

  AST_PARITY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_selected |-> ^r.word)
    else $error("Reply word parity is even");

  AST_GLOBAL_ONCE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bad_bit_count_i [*2] |-> !glob[0])
    else $error("Persisting global fault queued again");

  AST_GLOBAL_FIRST: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(bad_bit_count_i) && !r.glob_prev |-> push[0] && (code[0] == `SRWF_CODE_BAD_CNT))
    else $error("Bad bit count not queued on first channel");
endmodule

// File: rtl/srwf_pkg.sv
// Types of the satellite reply word formatter.
// Shared by the formatter and its self-checking bench.
package srwf_pkg;

  typedef enum logic [1:0] {
    SRWF_REP_FIFO = 2'h0,
    SRWF_REP_MCR = 2'h1,
    SRWF_REP_CCR = 2'h2,
    SRWF_REP_FIXED = 2'h3
  } srwf_rep_t;

  typedef enum logic [1:0] {
    SRWF_ST_OFF = 2'h0,
    SRWF_ST_ON_IDLE = 2'h1,
    SRWF_ST_ON_MSG = 2'h2,
    SRWF_ST_CFG = 2'h3
  } srwf_stat_t;

endpackage
